// ---- omsl_analog_model.sv ----
/*
 * behavioural model of the analog front end: crystal oscillator and synthesizer
 * assumes enables come from the sequencer on the same clock
 */
`timescale 1ns/1ps
module omsl_analog_model (
	input  wire logic clk_sys_i,
	input  wire logic osc_en_i,
	input  wire logic synth_en_i,
	output logic      osc_ready_o,
	output logic      pll_locked_o
);
	int c_osc = 0;
	int c_pll = 0;
	// settle times count from enable; ready drops at once when disabled
	always @(posedge clk_sys_i) begin
		c_osc <= osc_en_i ? c_osc + 1 : 0;
		c_pll <= synth_en_i ? c_pll + 1 : 0;
		osc_ready_o <= osc_en_i && c_osc > 20;
		pll_locked_o <= synth_en_i && c_pll > 30;
	end
endmodule

// ---- omsl_pin_if.sv ----
/*
 * carrier for asynchronous status pins and their synchronised copies
 * assumes the synchroniser and its user share one clock
 */
`timescale 1ns/1ps
interface omsl_pin_if #(parameter int N = 6);
	logic [N-1:0] raw;
	logic [N-1:0] sync;
	modport syncer (input raw, output sync);
	modport user (output raw, input sync);
endinterface

// ---- omsl_pkg.sv ----
/*
 * constants and types of the operating mode sequencer with duty-cycled receive
 * assumes a 10 MHz system clock and a 32-bit AHB-Lite register bus
 */
package omsl_pkg;

	// ********************************
	// register map
	// ********************************
	localparam logic [7:0] A_OPMODE = 8'h00;
	localparam logic [7:0] A_TXCFG  = 8'h04;
	localparam logic [7:0] A_LISTEN = 8'h08;
	localparam logic [7:0] A_LCOEF  = 8'h0C;
	localparam logic [7:0] A_PKTCFG = 8'h10;
	localparam logic [7:0] A_STATUS = 8'h14;

	localparam int OP_SEQOFF = 7;
	localparam int OP_LEN    = 6;
	localparam int OP_LABORT = 5;
	localparam int ST_TMO    = 9;

	localparam logic [7:0]  OPMODE_RST = 8'h00;
	localparam logic [23:0] TXCFG_RST  = 24'h006409;
	localparam logic [7:0]  LISTEN_RST = 8'h92;
	localparam logic [15:0] LCOEF_RST  = 16'h20F5;
	localparam logic [23:0] PKTCFG_RST = 24'h000301;

	localparam logic [2:0] MODE_SLEEP = 3'h0;
	localparam logic [2:0] MODE_STBY  = 3'h1;
	localparam logic [2:0] MODE_FS    = 3'h2;
	localparam logic [2:0] MODE_TX    = 3'h3;
	localparam logic [2:0] MODE_RX    = 3'h4;

	localparam logic [1:0] END_STAY   = 2'h0;
	localparam logic [1:0] END_MODE   = 2'h1;
	localparam logic [1:0] END_RESUME = 2'h2;

	// ********************************
	// timing
	// ********************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int T_PAREG_NS    = 5000;
	localparam int PAREG_CYC     = (T_PAREG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RES1_US       = 64;
	localparam int RES2_US       = 4100;
	localparam int RES3_US       = 262000;
	localparam int RES1_CYC      = RES1_US * 1000 / CLK_PERIOD_NS;
	localparam int RES2_CYC      = RES2_US * 1000 / CLK_PERIOD_NS;
	localparam int RES3_CYC      = RES3_US * 1000 / CLK_PERIOD_NS;
	localparam logic [3:0] PREAMBLE_LOCK_BITS = 4'hC;

	// ********************************
	// synchronised pins and block enables
	// ********************************
	localparam int PIN_OSC  = 0;
	localparam int PIN_PLL  = 1;
	localparam int PIN_RSSI = 2;
	localparam int PIN_SYNC = 3;
	localparam int PIN_PAY  = 4;
	localparam int PIN_TRIG = 5;
	localparam int PIN_N    = 6;

	localparam int B_RC   = 0;
	localparam int B_OSC  = 1;
	localparam int B_SYN  = 2;
	localparam int B_PAR  = 3;
	localparam int B_RAMP = 4;
	localparam int B_TX   = 5;
	localparam int B_RX   = 6;
	localparam int BLK_N  = 7;

	typedef enum logic [9:0] {
		S_STABLE = 10'h001,
		S_OSC    = 10'h002,
		S_PLL    = 10'h004,
		S_PAREG  = 10'h008,
		S_RAMP   = 10'h010,
		S_HALF   = 10'h020,
		S_L_IDLE = 10'h040,
		S_L_RX   = 10'h080,
		S_L_KEEP = 10'h100,
		S_L_DONE = 10'h200
	} omsl_state_t;

endpackage

// ---- omsl_sync.sv ----
/*
 * two-stage synchroniser for the analog and packet-engine status pins
 * assumes the pins are levels held for several clock cycles
 */
`timescale 1ns/1ps
module omsl_sync #(
	parameter int N = 6
) (
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic reset_i,
	// pins
	omsl_pin_if.syncer pins
);
	logic [N-1:0] meta_reg;
	logic [N-1:0] sync_reg;

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= pins.raw;
			sync_reg <= meta_reg;
		end
	end

	assign pins.sync = sync_reg;
endmodule

// ---- omsl_top.sv ----
/*
 * operating mode sequencer: basic modes, wake-up ordering, tx startup delay,
 * ready flags, preamble lock and the duty-cycled listen engine
 * assumes an AHB-Lite master on clk_sys_i and asynchronous status pins
 */
//
// Overview of operation
// - listen off: mode field selects sleep, standby, synthesizer, transmit or receive blocks
// - sequencer disabled: selected mode entered at once, no wake-up ordering
// - sleep to transmit walks standby, synthesizer, then transmit after PLL lock
// - transmit entry: PA regulator, then PA ramp, then bit clock output
// - PLL lock indicator follows the synthesizer lock
// - tx startup delay is 5 us plus 1.25 ramp time plus half bit
// - mode-reached and transmitter-ready flags tell host transmitter is ready
// - packet mode sends preamble at ready, packet starts on send trigger
// - receiver-ready flag; continuous without bit sync gives data at once
// - packet or bit sync mode waits 12 preamble bits before accepting data
// - listen idle runs only the RC oscillator, receiver wakes periodically
// - no detection in rx window turns receiver off; detection keeps it on
// - each window lasts its coefficient, 1 to 255, times its resolution
// - resolution codes 01, 10, 11 give 64 us, 4.1 ms, 262 ms
// - rx window includes the receiver wake-up time
// - criterion 0 needs signal level; 1 also needs sync/address hit
// - action 00 stays in receive, listen stops until host clears enable
// - action 01 waits payload or timeout, then goes to the mode field
// - action 10 waits payload or timeout, resumes idle, FIFO cleared next wake
// - timeout raised when signal level not reached in time in receive
`timescale 1ns/1ps
module omsl_top
	import omsl_pkg::*;
#(
	parameter int RES2_CYCLES = RES2_CYC,
	parameter int RES3_CYCLES = RES3_CYC
) (
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        reset_i,
	// AHB-Lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic        hready_i,
	input  wire logic [31:0] hwdata_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// status pins
	input  wire logic        osc_ready_i,
	input  wire logic        pll_locked_i,
	input  wire logic        signal_level_threshold_i,
	input  wire logic        sync_addr_hit_flag_i,
	input  wire logic        payload_complete_flag_i,
	input  wire logic        packet_send_trigger_i,
	// block enables
	output logic             rc_osc_en_o,
	output logic             osc_en_o,
	output logic             synth_en_o,
	output logic             pa_reg_en_o,
	output logic             pa_ramp_o,
	output logic             tx_en_o,
	output logic             rx_en_o,
	// flags and data path control
	output logic             pll_lock_o,
	output logic             mode_reached_flag_o,
	output logic             transmitter_ready_flag_o,
	output logic             receiver_ready_flag_o,
	output logic             bit_clock_out_o,
	output logic             preamble_send_o,
	output logic             packet_start_o,
	output logic [7:0]       preamble_count_o,
	output logic             data_accept_o,
	output logic             rx_timeout_o,
	output logic             fifo_clear_o
);
	if (RES2_CYCLES < 2 || RES3_CYCLES < RES2_CYCLES || RES3_CYCLES > 4194303) begin : g_bad_res
		$error("omsl_top: listen resolution counts out of range");
	end

	// ********************************
	// pin synchronisers
	// ********************************
	omsl_pin_if #(.N(PIN_N)) pins ();
	assign pins.raw = {packet_send_trigger_i, payload_complete_flag_i, sync_addr_hit_flag_i,
		signal_level_threshold_i, pll_locked_i, osc_ready_i};
	omsl_sync #(.N(PIN_N)) u_sync (
		.clk_sys_i (clk_sys_i),
		.reset_i   (reset_i),
		.pins      (pins.syncer)
	);
	logic [PIN_N-1:0] pin_s;
	assign pin_s = pins.sync;

	// ********************************
	// register bus
	// ********************************
	logic [7:0]  opmode_reg;
	logic [23:0] txcfg_reg;
	logic [7:0]  listen_reg;
	logic [15:0] lcoef_reg;
	logic [23:0] pktcfg_reg;
	logic        tmo_flag_reg;
	logic        wr_pend_reg;
	logic [7:0]  wr_addr_reg;
	logic        go_reg;
	logic [31:0] status_c;
	logic        tmo_fire;
	logic        addr_ph;

	assign addr_ph = hsel_i && htrans_i[1] && hready_i;

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata_o    <= 32'h00000000;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end else begin
			wr_pend_reg <= addr_ph && hwrite_i;
			wr_addr_reg <= haddr_i[7:0];
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
			if (addr_ph && !hwrite_i) begin
				case (haddr_i[7:0])
					A_OPMODE: hrdata_o <= {24'h000000, opmode_reg};
					A_TXCFG:  hrdata_o <= {8'h00, txcfg_reg};
					A_LISTEN: hrdata_o <= {24'h000000, listen_reg};
					A_LCOEF:  hrdata_o <= {16'h0000, lcoef_reg};
					A_PKTCFG: hrdata_o <= {8'h00, pktcfg_reg};
					A_STATUS: hrdata_o <= status_c;
					default:  hrdata_o <= 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			opmode_reg   <= OPMODE_RST;
			txcfg_reg    <= TXCFG_RST;
			listen_reg   <= LISTEN_RST;
			lcoef_reg    <= LCOEF_RST;
			pktcfg_reg   <= PKTCFG_RST;
			tmo_flag_reg <= 1'b0;
			go_reg       <= 1'b0;
		end else begin
			go_reg <= wr_pend_reg && wr_addr_reg == A_OPMODE;
			if (wr_pend_reg) begin
				case (wr_addr_reg)
					A_OPMODE: opmode_reg <= hwdata_i[7:0];
					A_TXCFG:  txcfg_reg  <= hwdata_i[23:0];
					A_LISTEN: listen_reg <= hwdata_i[7:0];
					A_LCOEF:  lcoef_reg  <= hwdata_i[15:0];
					A_PKTCFG: pktcfg_reg <= hwdata_i[23:0];
					default:  ;
				endcase
			end
			// a timeout in the clearing cycle survives the clear
			if (tmo_fire) begin
				tmo_flag_reg <= 1'b1;
			end else if (wr_pend_reg && wr_addr_reg == A_STATUS && hwdata_i[ST_TMO]) begin
				tmo_flag_reg <= 1'b0;
			end
		end
	end

	// ********************************
	// field decode
	// ********************************
	logic [2:0]  mode_f;
	logic        seqoff_f;
	logic        len_f;
	logic        labort_f;
	logic [15:0] ramp_cyc;
	logic [15:0] half_cyc;
	logic [1:0]  end_f;
	logic        crit_f;
	logic        pkt_f;
	logic        bsync_f;

	assign mode_f   = opmode_reg[2:0];
	assign seqoff_f = opmode_reg[OP_SEQOFF];
	assign len_f    = opmode_reg[OP_LEN];
	assign labort_f = opmode_reg[OP_LABORT];
	assign ramp_cyc = 16'((({8'h00, txcfg_reg[7:0]} * 16'd25) + 16'd1) >> 1);
	assign half_cyc = (txcfg_reg[23:9] == 15'h0000) ? 16'h0001 : {1'b0, txcfg_reg[23:9]};
	assign end_f    = listen_reg[2:1];
	assign crit_f   = listen_reg[3];
	assign pkt_f    = pktcfg_reg[0];
	assign bsync_f  = pktcfg_reg[1];

	function automatic logic [21:0] res_cycles(input logic [1:0] code);
		case (code)
			2'h2:    res_cycles = 22'(RES2_CYCLES);
			2'h3:    res_cycles = 22'(RES3_CYCLES);
			default: res_cycles = 22'(RES1_CYC);
		endcase
	endfunction

	function automatic omsl_state_t walk_start(input logic [2:0] m, input logic off);
		if (off || m == MODE_SLEEP)
			walk_start = S_STABLE;
		else
			walk_start = S_OSC;
	endfunction

	// ********************************
	// sequencer
	// ********************************
	omsl_state_t state_reg;
	omsl_state_t state_d_reg;
	logic [15:0] step_cnt_reg;
	logic        halt_reg;
	logic        discard_reg;
	logic        listen_on;
	logic        in_listen;
	logic        detect;
	logic        win_done;
	logic        rx_ready_c;
	logic        tx_ready_c;

	assign listen_on = len_f && !labort_f && !halt_reg;
	assign in_listen = state_reg == S_L_IDLE || state_reg == S_L_RX || state_reg == S_L_KEEP;
	assign detect    = pin_s[PIN_RSSI] && (!crit_f || pin_s[PIN_SYNC]);

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state_reg    <= S_STABLE;
			step_cnt_reg <= 16'h0000;
			halt_reg     <= 1'b0;
			discard_reg  <= 1'b0;
		end else begin
			step_cnt_reg <= step_cnt_reg + 16'h0001;
			if (!len_f)
				halt_reg <= 1'b0;
			if (listen_on && !in_listen) begin
				state_reg <= S_L_IDLE;
			end else if (in_listen && !listen_on) begin
				state_reg    <= walk_start(mode_f, seqoff_f);
				step_cnt_reg <= 16'h0000;
			end else if (go_reg && !in_listen && state_reg != S_L_DONE) begin
				state_reg    <= walk_start(mode_f, seqoff_f);
				step_cnt_reg <= 16'h0000;
			end else begin
				case (state_reg)
					S_OSC: if (pin_s[PIN_OSC])
						state_reg <= (mode_f == MODE_STBY) ? S_STABLE : S_PLL;
					S_PLL: if (pin_s[PIN_PLL]) begin
						state_reg    <= (mode_f == MODE_TX) ? S_PAREG : S_STABLE;
						step_cnt_reg <= 16'h0000;
					end
					S_PAREG: if (step_cnt_reg >= 16'(PAREG_CYC - 1)) begin
						state_reg    <= S_RAMP;
						step_cnt_reg <= 16'h0000;
					end
					S_RAMP: if (step_cnt_reg + 16'h0001 >= ramp_cyc) begin
						state_reg    <= S_HALF;
						step_cnt_reg <= 16'h0000;
					end
					S_HALF: if (step_cnt_reg + 16'h0001 >= half_cyc)
						state_reg <= S_STABLE;
					S_L_IDLE: if (win_done)
						state_reg <= S_L_RX;
					S_L_RX: if (detect)
						state_reg <= S_L_KEEP;
					else if (win_done || tmo_fire)
						state_reg <= S_L_IDLE;
					S_L_KEEP: case (end_f)
						END_STAY: begin
							state_reg <= S_L_DONE;
							halt_reg  <= 1'b1;
						end
						END_MODE: if (pin_s[PIN_PAY] || tmo_fire) begin
							state_reg    <= walk_start(mode_f, seqoff_f);
							step_cnt_reg <= 16'h0000;
							halt_reg     <= 1'b1;
						end
						default: if (pin_s[PIN_PAY] || tmo_fire) begin
							state_reg   <= S_L_IDLE;
							discard_reg <= 1'b1;
						end
					endcase
					S_L_DONE: if (!len_f) begin
						state_reg    <= walk_start(mode_f, seqoff_f);
						step_cnt_reg <= 16'h0000;
					end
					default: ;
				endcase
			end
			if (state_reg == S_L_RX)
				discard_reg <= 1'b0;
		end
	end

	// ********************************
	// listen windows
	// ********************************
	logic [21:0] res_cnt_reg;
	logic [7:0]  coef_cnt_reg;
	logic [21:0] res_lim;
	logic [7:0]  coef_lim;
	logic        res_tick;

	always_comb begin
		res_lim  = (state_reg == S_L_RX) ? res_cycles(listen_reg[5:4]) : res_cycles(listen_reg[7:6]);
		coef_lim = (state_reg == S_L_RX) ? lcoef_reg[15:8] : lcoef_reg[7:0];
		if (coef_lim == 8'h00)
			coef_lim = 8'h01;
	end
	assign res_tick = res_cnt_reg + 22'h000001 >= res_lim;
	assign win_done = res_tick && coef_cnt_reg + 8'h01 >= coef_lim;

	always_ff @(posedge clk_sys_i) begin
		state_d_reg <= reset_i ? S_STABLE : state_reg;
		// rx window starts at entry, wake-up time included
		if (reset_i || state_reg != state_d_reg || !(state_reg == S_L_IDLE || state_reg == S_L_RX)) begin
			res_cnt_reg  <= 22'h000000;
			coef_cnt_reg <= 8'h00;
		end else if (res_tick) begin
			res_cnt_reg  <= 22'h000000;
			coef_cnt_reg <= coef_cnt_reg + 8'h01;
		end else begin
			res_cnt_reg <= res_cnt_reg + 22'h000001;
		end
	end

	// ********************************
	// bit timing, preamble lock, timeout
	// ********************************
	logic [15:0] half_cnt_reg;
	logic        phase_reg;
	logic        bit_tick;
	logic [3:0]  pre_cnt_reg;
	logic [11:0] tmo_cnt_reg;
	logic        seen_reg;
	logic        started_reg;

	assign bit_tick   = half_cnt_reg + 16'h0001 >= half_cyc && phase_reg;
	assign rx_ready_c = (state_reg == S_STABLE && mode_f == MODE_RX) || state_reg == S_L_RX
		|| state_reg == S_L_KEEP || state_reg == S_L_DONE;
	assign tx_ready_c = state_reg == S_STABLE && mode_f == MODE_TX;
	assign tmo_fire   = rx_ready_c && !seen_reg && pktcfg_reg[23:16] != 8'h00 && bit_tick
		&& tmo_cnt_reg + 12'h001 == {pktcfg_reg[23:16], 4'h0};

	always_ff @(posedge clk_sys_i) begin
		if (reset_i || !(rx_ready_c || tx_ready_c)) begin
			half_cnt_reg <= 16'h0000;
			phase_reg    <= 1'b0;
		end else if (half_cnt_reg + 16'h0001 >= half_cyc) begin
			half_cnt_reg <= 16'h0000;
			phase_reg    <= !phase_reg;
		end else begin
			half_cnt_reg <= half_cnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i || !rx_ready_c || state_reg != state_d_reg) begin
			pre_cnt_reg <= 4'h0;
			tmo_cnt_reg <= 12'h000;
			seen_reg    <= 1'b0;
		end else begin
			if (bit_tick && pre_cnt_reg != PREAMBLE_LOCK_BITS)
				pre_cnt_reg <= pre_cnt_reg + 4'h1;
			if (pin_s[PIN_RSSI])
				seen_reg <= 1'b1;
			if (bit_tick && !seen_reg)
				tmo_cnt_reg <= tmo_cnt_reg + 12'h001;
		end
	end

	// ********************************
	// outputs
	// ********************************
	logic [BLK_N-1:0] blk_c;

	always_comb begin
		blk_c = '0;
		case (state_reg)
			S_STABLE: begin
				blk_c[B_OSC] = mode_f != MODE_SLEEP;
				blk_c[B_SYN] = mode_f == MODE_FS || mode_f == MODE_TX || mode_f == MODE_RX;
				blk_c[B_PAR] = mode_f == MODE_TX;
				blk_c[B_RAMP] = mode_f == MODE_TX;
				blk_c[B_TX] = mode_f == MODE_TX;
				blk_c[B_RX] = mode_f == MODE_RX;
			end
			S_OSC:   blk_c[B_OSC] = 1'b1;
			S_PLL:   blk_c[B_SYN:B_OSC] = 2'h3;
			S_PAREG: blk_c[B_PAR:B_OSC] = 3'h7;
			S_RAMP, S_HALF: blk_c[B_RAMP:B_OSC] = 4'hF;
			S_L_IDLE: blk_c[B_RC] = 1'b1;
			S_L_RX, S_L_KEEP: blk_c = 7'h47;
			S_L_DONE: blk_c = 7'h46;
			default: blk_c = '0;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			{rx_en_o, tx_en_o, pa_ramp_o, pa_reg_en_o, synth_en_o, osc_en_o, rc_osc_en_o} <= '0;
			pll_lock_o               <= 1'b0;
			mode_reached_flag_o      <= 1'b0;
			transmitter_ready_flag_o <= 1'b0;
			receiver_ready_flag_o    <= 1'b0;
			bit_clock_out_o          <= 1'b0;
			preamble_send_o          <= 1'b0;
			packet_start_o           <= 1'b0;
			started_reg              <= 1'b0;
			preamble_count_o         <= 8'h00;
			data_accept_o            <= 1'b0;
			rx_timeout_o             <= 1'b0;
			fifo_clear_o             <= 1'b0;
		end else begin
			{rx_en_o, tx_en_o, pa_ramp_o, pa_reg_en_o, synth_en_o, osc_en_o, rc_osc_en_o} <= blk_c;
			pll_lock_o               <= pin_s[PIN_PLL] && blk_c[B_SYN];
			mode_reached_flag_o      <= state_reg == S_STABLE && !go_reg;
			transmitter_ready_flag_o <= tx_ready_c && !go_reg;
			receiver_ready_flag_o    <= rx_ready_c;
			bit_clock_out_o          <= tx_ready_c && phase_reg;
			preamble_send_o          <= tx_ready_c && pkt_f;
			packet_start_o           <= tx_ready_c && pkt_f && pin_s[PIN_TRIG] && !started_reg;
			started_reg              <= tx_ready_c && (started_reg || (pkt_f && pin_s[PIN_TRIG]));
			preamble_count_o         <= pktcfg_reg[15:8];
			data_accept_o            <= rx_ready_c && (!(pkt_f || bsync_f) || pre_cnt_reg == PREAMBLE_LOCK_BITS);
			rx_timeout_o             <= tmo_fire;
			fifo_clear_o             <= state_reg == S_L_RX && state_d_reg == S_L_IDLE && discard_reg;
		end
	end

	assign status_c = {21'h000000, tmo_flag_reg, halt_reg, state_reg == S_L_RX, pll_lock_o,
		receiver_ready_flag_o, transmitter_ready_flag_o, mode_reached_flag_o, data_accept_o, mode_f};

	// ********************************
	// assertions
	// ********************************
	a_sleep_all_off: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		state_reg == S_STABLE && mode_f == MODE_SLEEP |=> !osc_en_o && !synth_en_o && !tx_en_o && !rx_en_o)
		else $error("sleep left a block enabled");
	a_direct_entry: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		go_reg && seqoff_f && !listen_on && !in_listen && state_reg != S_L_DONE |=> state_reg == S_STABLE)
		else $error("sequencer-off write did not enter mode directly");
	a_lock_before_pa: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		state_reg == S_PAREG && $past(state_reg) != S_PAREG |-> $past(state_reg) == S_PLL && $past(pin_s[PIN_PLL]))
		else $error("transmit path entered without PLL lock");
	a_pareg_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		state_reg == S_PAREG && step_cnt_reg < 16'(PAREG_CYC - 1) && !go_reg && !listen_on |=> state_reg == S_PAREG)
		else $error("PA regulator step shorter than 5 us");
	a_bitclk_ready: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		bit_clock_out_o |-> transmitter_ready_flag_o || $past(state_reg) == S_STABLE)
		else $error("bit clock before transmitter ready");
	a_txrdy_modeok: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		transmitter_ready_flag_o |-> mode_reached_flag_o)
		else $error("transmitter ready without mode reached");
	a_pkt_preamble: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		packet_start_o |-> preamble_send_o ##1 !packet_start_o)
		else $error("packet start without preamble or held");
	a_preamble_lock: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		$rose(data_accept_o) && (pkt_f || bsync_f) |-> $past(pre_cnt_reg) == PREAMBLE_LOCK_BITS)
		else $error("data accepted before 12 preamble bits");
	a_idle_rc_only: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		state_reg == S_L_IDLE |=> rc_osc_en_o && !osc_en_o && !rx_en_o)
		else $error("listen idle runs more than the RC oscillator");
	a_window_end: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		state_reg == S_L_RX && win_done && !detect && listen_on |=> state_reg == S_L_IDLE)
		else $error("rx window did not close without detection");
	a_busy_no_ready: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		state_reg != S_STABLE |=> !mode_reached_flag_o)
		else $error("mode reached during transition");
endmodule

// ---- omsl_top_test.sv ----
/*
 * self-checking bench of the operating mode sequencer
 * assumes the analog model answers the oscillator and synthesizer enables
 */
`timescale 1ns/1ps
module omsl_top_test;
	import omsl_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, oscr, pll;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	logic        osc_en, syn, pareg, tx, rx, lock, mr, txr, rxr, rco, bck, b, pre, pst, acc, tmo, pa;
	logic        sl = 1'b0, pay = 1'b0, trig = 1'b0;
	logic [7:0]  lfsr, pcnt;
	logic [2:0]  m;
	int          n_mismatch = 0, compares = 0, k, nt, npst = 0, ntmo = 0;

	omsl_top #(.RES2_CYCLES(20), .RES3_CYCLES(40)) u_dut (.clk_sys_i(clk), .reset_i(rst),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
		.hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
		.osc_ready_i(oscr), .pll_locked_i(pll), .signal_level_threshold_i(sl),
		.sync_addr_hit_flag_i(1'b0), .payload_complete_flag_i(pay), .packet_send_trigger_i(trig),
		.rc_osc_en_o(rco), .osc_en_o(osc_en), .synth_en_o(syn), .pa_reg_en_o(pareg), .pa_ramp_o(),
		.tx_en_o(tx), .rx_en_o(rx), .pll_lock_o(lock), .mode_reached_flag_o(mr),
		.transmitter_ready_flag_o(txr), .receiver_ready_flag_o(rxr), .bit_clock_out_o(bck),
		.preamble_send_o(pre), .packet_start_o(pst), .preamble_count_o(pcnt), .data_accept_o(acc),
		.rx_timeout_o(tmo), .fifo_clear_o());
	omsl_analog_model u_ana (.clk_sys_i(clk), .osc_en_i(osc_en), .synth_en_i(syn),
		.osc_ready_o(oscr), .pll_locked_o(pll));

	always #50 clk = ~clk;

	// counts of one-cycle pulses
	always @(posedge clk) begin
		if (pst === 1'b1)
			npst++;
		if (tmo === 1'b1)
			ntmo++;
	end

	function automatic logic [7:0] lfsr_next(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	function automatic logic [31:0] exp_blk(input logic [2:0] md);
		return {28'h0, md >= 3'h2, md == MODE_TX, md == MODE_RX, md == MODE_RX};
	endfunction

	task automatic summarize;
		if (n_mismatch == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic wait_mode;
		repeat (4) @(posedge clk);
		k = 0;
		pa = 1'b0;
		while (mr !== 1'b1 && k < 3000) begin
			@(posedge clk);
			k++;
			// the regulator stage starts only after lock, with the flag still down
			if (pareg === 1'b1 && !pa) begin
				chk("lock_at_pa", 32'h2, {lock, mr});
				pa = 1'b1;
			end
		end
	endtask
	task automatic wait_rx(input logic v);
		k = 0;
		while (rx !== v && k < 2000) begin
			@(posedge clk);
			k++;
		end
	endtask

	initial begin
		lfsr = 8'h1C;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(1'b0, {24'h0, A_LISTEN}, 32'h0);
		chk("listen_reset", {24'h0, LISTEN_RST}, r);
		bus(1'b0, 32'h40, 32'h0);
		chk("unmapped", 32'h0, r);
		bus(1'b1, {24'h0, A_OPMODE}, {29'h0, MODE_TX});
		wait_mode;
		chk("tx_walk_done", 32'h1, pa);
		chk("tx_ready", 32'h1F, {27'h0, syn, tx, txr, lock, mr});
		trig <= 1'b1;
		b = bck;
		nt = 0;
		repeat (200) begin
			@(posedge clk);
			if (bck !== b)
				nt++;
			b = bck;
		end
		trig <= 1'b0;
		// 200 cycles hold four half periods of a 100-cycle bit
		chk("bit_clock", 32'h1, nt >= 3 && nt <= 5);
		chk("packet_start", 32'h1, npst);
		chk("preamble", {23'h0, 1'b1, PKTCFG_RST[15:8]}, {pre, pcnt});
		bus(1'b1, {24'h0, A_OPMODE}, {29'h0, MODE_RX});
		wait_mode;
		bus(1'b1, {24'h0, A_OPMODE}, {29'h0, MODE_TX});
		wait_mode;
		chk("tx_hop", 32'h7, {tx, txr, pa});
		bus(1'b1, {24'h0, A_OPMODE}, {29'h0, MODE_FS});
		wait_mode;
		bus(1'b1, {24'h0, A_OPMODE}, {29'h0, MODE_RX});
		wait_mode;
		chk("rx_hop", 32'h2, {rxr, acc});
		// 12 bits of 100 cycles each, plus margin
		repeat (1300) @(posedge clk);
		chk("rx_locked", 32'h1, acc);
		bus(1'b1, {24'h0, A_PKTCFG}, 32'h00010301);
		repeat (500) @(posedge clk);
		chk("rx_timeout", 32'h1, ntmo);
		bus(1'b0, {24'h0, A_STATUS}, 32'h0);
		chk("timeout_flag", 32'h1, r[10]);
		for (int i = 0; i < 8; i++) begin
			lfsr = lfsr_next(lfsr);
			m = 3'(lfsr % 5);
			bus(1'b1, {24'h0, A_OPMODE}, {24'h0, 8'h80 | {5'h0, m}});
			wait_mode;
			chk("direct_fast", 32'h1, k < 20);
			chk("blocks", exp_blk(m), {28'h0, syn, tx, rx, rxr});
		end
		bus(1'b1, {24'h0, A_LCOEF}, 32'h00000102);
		bus(1'b1, {24'h0, A_OPMODE}, 32'h00000041);
		repeat (10) @(posedge clk);
		chk("listen_idle", 32'h4, {rco, osc_en, rx});
		wait_rx(1'b1);
		// idle window is two coefficients of 20 cycles
		chk("idle_window", 32'h1, k + 10 >= 40 && k + 10 <= 48);
		wait_rx(1'b0);
		chk("rx_window", 32'h1, k >= RES1_CYC && k <= RES1_CYC + 4);
		sl <= 1'b1;
		wait_rx(1'b1);
		repeat (RES1_CYC + 50) @(posedge clk);
		chk("rx_kept", 32'h1, rx);
		pay <= 1'b1;
		wait_mode;
		bus(1'b0, {24'h0, A_STATUS}, 32'h0);
		chk("listen_end", 32'h5, {r[9], rx, osc_en});
		bus(1'b1, {24'h0, A_OPMODE}, 32'h00000021);
		bus(1'b1, {24'h0, A_OPMODE}, {29'h0, MODE_STBY});
		wait_mode;
		bus(1'b0, {24'h0, A_STATUS}, 32'h0);
		chk("listen_abort", 32'h1, {r[9], r[4]});
		summarize;
	end

	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		summarize;
	end
endmodule
